/* File: wdpfs_pkg.sv */
// package for the watchdog and power-fail supervisor
// assumes a single 40 MHz core_clk domain and an 8-bit special register bus
package wdpfs_pkg;

  // ==========================================================================
  // register addresses on the special register bus
  localparam logic [7:0] ADDR_CLKSEL = 8'h8E; // clock_rate_and_watchdog_select
  localparam logic [7:0] ADDR_EXIF = 8'h91;   // band-gap stop select lives here
  localparam logic [7:0] ADDR_TA = 8'hC7;     // timed-access key register
  localparam logic [7:0] ADDR_WDCTL = 8'hD8;  // watchdog_power_fail_control
  localparam logic [7:0] ADDR_EIE = 8'hE8;    // extended_irq_enable

  // ==========================================================================
  // field positions
  localparam int SEL_HI = 7;          // timeout_select_hi
  localparam int SEL_LO = 6;          // timeout_select_lo
  localparam int WDC_POR = 6;         // power-on reset flag
  localparam int WDC_PFI_EN = 5;      // early_power_warning_irq enable
  localparam int WDC_PFI_FLAG = 4;    // early_power_warning_irq flag
  localparam int WDC_WD_IRQ = 3;      // wd_irq_flag
  localparam int WDC_WD_RST = 2;      // wd_reset_flag
  localparam int WDC_WD_RST_EN = 1;   // wd_reset_enable
  localparam int WDC_RESTART = 0;     // wd_restart
  localparam int EIE_WD_IRQ_EN = 4;   // wd_irq_enable
  localparam int EXIF_BGS = 0;        // bandgap_in_stop_select

  // ==========================================================================
  // reset values and the unmapped read value
  localparam logic [7:0] CLKSEL_RST = 8'h00;
  localparam logic [7:0] EIE_RST = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ==========================================================================
  // timed access
  localparam logic [7:0] TA_KEY_FIRST = 8'hAA;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;
  localparam logic [1:0] TA_WINDOW_CLKS = 2'h3;

  // ==========================================================================
  // timing counts in crystal clocks
  localparam int WD_CNT_W = 26;
  localparam int WD_TAIL_CLKS = 512;
  localparam logic [8:0] WD_TAIL_LAST = 9'(WD_TAIL_CLKS - 1);
  localparam int unsigned WD_INT_CLKS_SEL0 = 131072;
  localparam int unsigned WD_INT_CLKS_SEL1 = 1048576;
  localparam int unsigned WD_INT_CLKS_SEL2 = 8388608;
  localparam int unsigned WD_INT_CLKS_SEL3 = 67108864;
  localparam int POR_CNT_W = 16;
  localparam int unsigned POR_CLKS = 65536;

  // ==========================================================================
  // interrupt vectors
  localparam logic [15:0] VEC_PFI = 16'h0033;
  localparam logic [15:0] VEC_WD = 16'h0063;
  localparam logic [15:0] VEC_NONE = 16'h0000;

  // ==========================================================================
  // power-on sequencer states
  typedef enum logic [1:0] {POR_LOW, POR_COUNT, POR_RUN} wdpfs_por_state_t;

endpackage : wdpfs_pkg

/* File: wdpfs_ta_if.sv */
// interface between the supervisor core and its timed-access guard
// assumes both ends sit on core_clk
`timescale 1ns/1ps
interface wdpfs_ta_if;
  logic wrStrobe;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic accessOpen;

  modport core (output wrStrobe, output wrAddr, output wrData,
                input accessOpen);
  modport guard (input wrStrobe, input wrAddr, input wrData,
                 output accessOpen);
endinterface : wdpfs_ta_if

/* File: wdpfs_sync.sv */
// two-stage synchroniser for pin-level inputs
// assumes inputs are slow levels from outside the core_clk domain
`timescale 1ns/1ps
module wdpfs_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule : wdpfs_sync

/* File: wdpfs_timed_access.sv */
// timed-access guard: key AA then 55 opens a short write window
// assumes one bus write per cycle at most, shared with the core
`timescale 1ns/1ps
module wdpfs_timed_access (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // bus view and window
  wdpfs_ta_if.guard ta
);
  import wdpfs_pkg::*;

  typedef enum logic [1:0] {TA_IDLE, TA_ARMED, TA_OPEN} wdpfs_ta_state_t;

  wdpfs_ta_state_t state;
  logic [1:0] windowLeft;

  // ==========================================================================
  // key decode
  wire taWr = ta.wrStrobe && (ta.wrAddr == ADDR_TA);
  wire keyFirst = taWr && (ta.wrData == TA_KEY_FIRST);
  wire keySecond = taWr && (ta.wrData == TA_KEY_SECOND);

  assign ta.accessOpen = (state == TA_OPEN);

  // any foreign write between the keys disarms, so keys must be back to back
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= TA_IDLE;
      windowLeft <= 2'h0;
    end else begin
      unique case (state)
        TA_IDLE: begin
          if (keyFirst) state <= TA_ARMED;
        end
        TA_ARMED: begin
          if (keySecond) begin
            state <= TA_OPEN;
            windowLeft <= TA_WINDOW_CLKS;
          end else if (ta.wrStrobe && !keyFirst) begin
            state <= TA_IDLE;
          end
        end
        TA_OPEN: begin
          if (keyFirst) state <= TA_ARMED;
          else if (windowLeft == 2'h1) state <= TA_IDLE;
          windowLeft <= windowLeft - 2'h1;
        end
      endcase
    end
  end
endmodule : wdpfs_timed_access

/* File: wdpfs_supervisor.sv */
// watchdog timer, power-on/brown-out reset hold and power-fail warning
// assumes supply comparators arrive as raw pin levels and that the core
// reaches the registers over a simple strobe bus on core_clk
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

module wdpfs_supervisor #(
  parameter int unsigned WD_CLKS_SEL0 = wdpfs_pkg::WD_INT_CLKS_SEL0,
  parameter int unsigned WD_CLKS_SEL1 = wdpfs_pkg::WD_INT_CLKS_SEL1,
  parameter int unsigned WD_CLKS_SEL2 = wdpfs_pkg::WD_INT_CLKS_SEL2,
  parameter int unsigned WD_CLKS_SEL3 = wdpfs_pkg::WD_INT_CLKS_SEL3,
  parameter int unsigned POR_HOLD_CLKS = wdpfs_pkg::POR_CLKS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register bus
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // supply comparator pins
  input wire logic supplyBelowReset,
  input wire logic supplyBelowWarning,
  // core status
  input wire logic stopMode,
  // reset, clock and interrupt outputs
  output logic cpuResetHold,
  output logic oscEnable,
  output logic wdIrqReq,
  output logic pfiIrqReq,
  output logic [15:0] irqVector,
  output logic stopWake
);
  import wdpfs_pkg::*;

  // ==========================================================================
  // pin synchronisation
  logic [1:0] pinSync;
  wire supplyLow = pinSync[0];
  wire supplyWarn = pinSync[1];

  wdpfs_sync #(.WIDTH(2)) u_pinSync (
    .core_clk(core_clk),
    .srst(srst),
    .asyncIn({supplyBelowWarning, supplyBelowReset}),
    .syncOut(pinSync)
  );

  // ==========================================================================
  // register decode
  wire selClk = (regAddr == ADDR_CLKSEL);
  wire selExif = (regAddr == ADDR_EXIF);
  wire selWdc = (regAddr == ADDR_WDCTL);
  wire selEie = (regAddr == ADDR_EIE);
  wire wrClk = regWr && selClk;
  wire wrExif = regWr && selExif;
  wire wrWdc = regWr && selWdc;
  wire wrEie = regWr && selEie;

  // ==========================================================================
  // timed-access guard
  wdpfs_ta_if taBus ();
  assign taBus.wrStrobe = regWr;
  assign taBus.wrAddr = regAddr;
  assign taBus.wrData = regWrData;

  wdpfs_timed_access u_ta (
    .core_clk(core_clk),
    .srst(srst),
    .ta(taBus.guard)
  );

  // protected bits only move inside the open window
  wire protWdc = wrWdc && taBus.accessOpen;
  wire protExif = wrExif && taBus.accessOpen;

  // ==========================================================================
  // software registers
  logic [7:0] clkSel;
  logic [7:0] extended_irq_enable;
  logic bandgap_in_stop_select;
  logic pfiEn;
  logic wdRstEn;

  // plain registers; protected ones follow the window
  always_ff @(posedge core_clk) begin
    if (srst) begin
      clkSel <= CLKSEL_RST;
      extended_irq_enable <= EIE_RST;
      bandgap_in_stop_select <= 1'b0;
      pfiEn <= 1'b0;
      wdRstEn <= 1'b0;
    end else begin
      if (wrClk) clkSel <= regWrData;
      if (wrEie) extended_irq_enable <= regWrData;
      if (protExif) bandgap_in_stop_select <= regWrData[EXIF_BGS];
      if (wrWdc) pfiEn <= regWrData[WDC_PFI_EN];
      if (protWdc) wdRstEn <= regWrData[WDC_WD_RST_EN];
    end
  end

  // ==========================================================================
  // power-on / brown-out sequencer
  wdpfs_por_state_t porState;
  wdpfs_por_state_t next_porState;
  logic [POR_CNT_W-1:0] porCount;
  logic porFlag;
  wire porLast = (porCount == POR_CNT_W'(POR_HOLD_CLKS - 1));
  wire porDone = (porState == POR_COUNT) && !supplyLow && porLast;

  // next state: any dip under the threshold drops back to the held state
  always_comb begin
    next_porState = porState;
    unique case (porState)
      POR_LOW: if (!supplyLow) next_porState = POR_COUNT;
      POR_COUNT: begin
        if (supplyLow) next_porState = POR_LOW;
        else if (porLast) next_porState = POR_RUN;
      end
      POR_RUN: if (supplyLow) next_porState = POR_LOW;
    endcase
  end

  // the hold count restarts from zero on every entry to counting
  always_ff @(posedge core_clk) begin
    if (srst) begin
      porState <= POR_LOW;
      porCount <= '0;
    end else begin
      porState <= next_porState;
      if (porState == POR_COUNT) porCount <= porCount + 1'b1;
      else porCount <= '0;
    end
  end

  // ==========================================================================
  // watchdog counter chain
  logic [WD_CNT_W-1:0] wdCount;
  logic [WD_CNT_W-1:0] wdLimit;
  logic [8:0] tailCount;
  logic tailActive;
  logic wdIrqFlag;
  logic wdRstFlag;
  wire [1:0] wdSel = {clkSel[SEL_HI], clkSel[SEL_LO]};
  wire restart = protWdc && regWrData[WDC_RESTART];
  wire chainHeld = (porState != POR_RUN);
  wire intHit = !tailActive && (wdCount == wdLimit);
  wire fullTimeout = tailActive && (tailCount == WD_TAIL_LAST);

  // terminal value is one less than the interval, counted from zero
  always_comb begin
    unique case (wdSel)
      2'h0: wdLimit = WD_CNT_W'(WD_CLKS_SEL0 - 1);
      2'h1: wdLimit = WD_CNT_W'(WD_CLKS_SEL1 - 1);
      2'h2: wdLimit = WD_CNT_W'(WD_CLKS_SEL2 - 1);
      2'h3: wdLimit = WD_CNT_W'(WD_CLKS_SEL3 - 1);
    endcase
  end

  // free running: after a full time-out the chain starts a new interval
  always_ff @(posedge core_clk) begin
    if (srst || chainHeld || restart || fullTimeout) begin
      wdCount <= '0;
      tailCount <= 9'h000;
      tailActive <= 1'b0;
    end else if (intHit) begin
      tailActive <= 1'b1;
      tailCount <= 9'h000;
    end else if (tailActive) begin
      tailCount <= tailCount + 9'h001;
    end else begin
      wdCount <= wdCount + 1'b1;
    end
  end

  // ==========================================================================
  // status flags: a hardware set in the clearing cycle wins
  logic pfiFlag;
  wire bandgapLive = !stopMode || bandgap_in_stop_select;
  wire pfiEvent = supplyWarn && bandgapLive;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wdIrqFlag <= 1'b0;
      wdRstFlag <= 1'b0;
      pfiFlag <= 1'b0;
      porFlag <= 1'b0;
    end else begin
      if (intHit) wdIrqFlag <= 1'b1;
      else if (protWdc) wdIrqFlag <= regWrData[WDC_WD_IRQ];
      // untouched by the watchdog reset so the cause stays readable
      if (fullTimeout) wdRstFlag <= 1'b1;
      else if (wrWdc && !regWrData[WDC_WD_RST]) wdRstFlag <= 1'b0;
      if (pfiEvent) pfiFlag <= 1'b1;
      else if (wrWdc && !regWrData[WDC_PFI_FLAG]) pfiFlag <= 1'b0;
      if (porDone) porFlag <= 1'b1;
      else if (protWdc) porFlag <= regWrData[WDC_POR];
    end
  end

  // ==========================================================================
  // reset, oscillator, interrupts and wake
  wire wdReset = fullTimeout && wdRstEn;
  wire nextHold = (next_porState != POR_RUN) || wdReset;

  assign wdIrqReq = wdIrqFlag && extended_irq_enable[EIE_WD_IRQ_EN];
  assign pfiIrqReq = pfiFlag && pfiEn;

  // the oscillator stays off only while the supply is too low to run it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cpuResetHold <= 1'b1;
      oscEnable <= 1'b0;
      irqVector <= VEC_NONE;
      stopWake <= 1'b0;
    end else begin
      cpuResetHold <= nextHold;
      oscEnable <= (next_porState != POR_LOW);
      if (pfiIrqReq) irqVector <= VEC_PFI;
      else if (wdIrqReq) irqVector <= VEC_WD;
      else irqVector <= VEC_NONE;
      stopWake <= stopMode && pfiEn && bandgap_in_stop_select && supplyWarn;
    end
  end

  // ==========================================================================
  // read path: restart bit and key register read as zero
  wire [7:0] wdcView = {1'b0, porFlag, pfiEn, pfiFlag, wdIrqFlag, wdRstFlag,
                        wdRstEn, 1'b0};
  wire [7:0] exifView = {7'h00, bandgap_in_stop_select};
  logic [7:0] rdMux;

  always_comb begin
    rdMux = RD_UNMAPPED;
    if (selClk) rdMux = clkSel;
    else if (selExif) rdMux = exifView;
    else if (selWdc) rdMux = wdcView;
    else if (selEie) rdMux = extended_irq_enable;
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (srst) regRdData <= 8'h00;
    else if (regRd) regRdData <= rdMux;
    else regRdData <= 8'h00;
  end
endmodule : wdpfs_supervisor

/* File: wdpfs_monitor.sv */
// checker on the supervisor top-level ports
// assumes one core_clk domain with synchronous active-high srst
`timescale 1ns/1ps
module wdpfs_monitor #(
  parameter int unsigned POR_HOLD_CLKS = 65536
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // observed ports
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic supplyBelowReset,
  input wire logic stopMode,
  input wire logic cpuResetHold,
  input wire logic oscEnable,
  input wire logic wdIrqReq,
  input wire logic pfiIrqReq,
  input wire logic [15:0] irqVector,
  input wire logic stopWake
);
  // ==========================================================================
  // helper: cycles the oscillator has run, saturating so it never wraps
  logic [16:0] oscCnt;
  logic [16:0] next_oscCnt;
  assign next_oscCnt = !oscEnable ? 17'h00000 :
                       (&oscCnt) ? oscCnt : oscCnt + 17'h00001;
  always_ff @(posedge core_clk) begin
    oscCnt <= srst ? 17'h00000 : next_oscCnt;
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_vecPfi;
    pfiIrqReq |=> irqVector == 16'h0033;
  endproperty
  a_vecPfi: assert property (p_vecPfi)
    else $error("power-fail vector missing");
  property p_vecWd;
    !pfiIrqReq && wdIrqReq |=> irqVector == 16'h0063;
  endproperty
  a_vecWd: assert property (p_vecWd)
    else $error("watchdog vector missing");
  property p_vecNone;
    !pfiIrqReq && !wdIrqReq |=> irqVector == 16'h0000;
  endproperty
  a_vecNone: assert property (p_vecNone)
    else $error("vector without request");
  property p_brownOut;
    supplyBelowReset [*3] |=> cpuResetHold && !oscEnable;
  endproperty
  a_brownOut: assert property (p_brownOut)
    else $error("low supply did not hold reset");
  property p_porHold;
    !oscEnable |-> cpuResetHold;
  endproperty
  a_porHold: assert property (p_porHold)
    else $error("reset released with oscillator off");
  // margin of two covers the sequencer's entry and enable latency
  property p_porCount;
    $fell(cpuResetHold) |-> int'(oscCnt) >= int'(POR_HOLD_CLKS) - 2;
  endproperty
  a_porCount: assert property (p_porCount)
    else $error("reset released before hold count");
  property p_wdPulse;
    $rose(cpuResetHold) && oscEnable |=> !cpuResetHold;
  endproperty
  a_wdPulse: assert property (p_wdPulse)
    else $error("watchdog reset pulse too long");
  property p_wake;
    stopWake |-> $past(stopMode);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake outside stop");
  property p_rdIdle;
    !$past(regRd) |-> regRdData == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data outside read slot");
endmodule : wdpfs_monitor

bind wdpfs_supervisor wdpfs_monitor #(.POR_HOLD_CLKS(POR_HOLD_CLKS))
  i_wdpfs_monitor (.core_clk, .srst, .regRd, .regRdData, .supplyBelowReset,
  .stopMode, .cpuResetHold, .oscEnable, .wdIrqReq, .pfiIrqReq, .irqVector,
  .stopWake);

/* File: wdpfs_supervisor_tb.sv */
// self-checking bench for the supervisor
// assumes shortened watchdog and hold counts set by parameters below
`timescale 1ns/1ps
module wdpfs_supervisor_tb;
  import wdpfs_pkg::*;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    err_total++; $display("ERROR t=%0t got %0h exp %0h", $time, a, b); \
  end end
  // ==========================================================================
  // stimulus signals and counts
  localparam int LEN [4] = '{8, 16, 32, 64};
  localparam int POR = 16;
  // rows: address, write data, value read back
  localparam logic [23:0] ROWS [6] = '{
    {ADDR_CLKSEL, 8'hA5, 8'hA5}, {ADDR_EIE, 8'h3C, 8'h3C},
    {8'h40, 8'hFF, RD_UNMAPPED}, {ADDR_TA, 8'h12, 8'h00},
    {ADDR_WDCTL, 8'h2B, 8'h60}, {ADDR_EXIF, 8'h01, 8'h00}};
  logic core_clk, srst, regWr, regRd, supplyBelowReset, supplyBelowWarning;
  logic stopMode, cpuResetHold, oscEnable, wdIrqReq, pfiIrqReq, stopWake;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [15:0] irqVector;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;

  wdpfs_supervisor #(.WD_CLKS_SEL0(LEN[0]), .WD_CLKS_SEL1(LEN[1]),
    .WD_CLKS_SEL2(LEN[2]), .WD_CLKS_SEL3(LEN[3]), .POR_HOLD_CLKS(POR))
    i_wdpfs_supervisor (.core_clk, .srst, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .supplyBelowReset, .supplyBelowWarning, .stopMode,
    .cpuResetHold, .oscEnable, .wdIrqReq, .pfiIrqReq, .irqVector, .stopWake);

  // ==========================================================================
  // clock and hang guard; the ceiling is several times the expected run
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      results();
    end
  end

  // ==========================================================================
  // bus tasks; a gap cycle after each strobe keeps drivers single-assigned
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
    @(posedge core_clk);
  endtask : rd
  task automatic ta(input logic [7:0] a, input logic [7:0] d);
    wr(ADDR_TA, TA_KEY_FIRST);
    wr(ADDR_TA, TA_KEY_SECOND);
    wr(a, d);
  endtask : ta
  // which: 0 irq request, 1 reset high, 2 reset low; n counts edges
  task automatic waitSig(input int which, output int n);
    n = 0;
    #1;
    while ((which == 0 ? wdIrqReq : which == 1 ? cpuResetHold :
           !cpuResetHold) !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    // a wait that runs out is a hang and counts against the run
    if (n >= 2000) err_total++;
  endtask : waitSig
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // ==========================================================================
  // main sequence
  initial begin
    int t;
    int n;
    logic [7:0] v;
    srst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    supplyBelowReset = 1'b0;
    supplyBelowWarning = 1'b0;
    stopMode = 1'b0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    waitSig(2, n);
    for (int r = 0; r < 6; r++) begin
      wr(ROWS[r][23:16], ROWS[r][15:8]);
      rd(ROWS[r][23:16], v);
      `CHK(v, ROWS[r][7:0])
    end
    // each select code, measured from a protected restart
    wr(ADDR_EIE, 8'h10);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CLKSEL, {c[1:0], 6'h00});
      ta(ADDR_WDCTL, 8'h23);
      waitSig(0, t);
      `CHK(t, LEN[c] - 1)
    end
    waitSig(1, n);
    `CHK(n, WD_TAIL_CLKS)
    rd(ADDR_WDCTL, v);
    `CHK(v[3:2], 2'b11)
    // reset disabled and irq masked: flags still set, no reset
    wr(ADDR_EIE, 8'h00);
    wr(ADDR_CLKSEL, 8'h00);
    ta(ADDR_WDCTL, 8'h21);
    n = 0;
    repeat (540) begin
      @(posedge core_clk);
      #1 n += int'(cpuResetHold);
    end
    `CHK(n, 0)
    `CHK(wdIrqReq, 1'b0)
    rd(ADDR_WDCTL, v);
    `CHK(v[3:1], 3'b110)
    // broken key order, then an expired window
    wr(ADDR_TA, TA_KEY_FIRST);
    wr(ADDR_CLKSEL, 8'h00);
    wr(ADDR_TA, TA_KEY_SECOND);
    wr(ADDR_WDCTL, 8'h22);
    wr(ADDR_TA, TA_KEY_FIRST);
    wr(ADDR_TA, TA_KEY_SECOND);
    repeat (3) @(posedge core_clk);
    wr(ADDR_WDCTL, 8'h22);
    rd(ADDR_WDCTL, v);
    `CHK(v[1], 1'b0)
    // power warning beside a pending watchdog request
    wr(ADDR_EIE, 8'h10);
    supplyBelowWarning <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 `CHK(pfiIrqReq, 1'b1)
    @(posedge core_clk);
    #1 `CHK(irqVector, VEC_PFI)
    supplyBelowWarning <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(ADDR_WDCTL, v);
    `CHK(v[4], 1'b1)
    wr(ADDR_WDCTL, 8'h20);
    rd(ADDR_WDCTL, v);
    `CHK(v[4], 1'b0)
    #1 `CHK(irqVector, VEC_WD)
    // wake from stop with the band-gap kept on
    ta(ADDR_EXIF, 8'h01);
    stopMode <= 1'b1;
    supplyBelowWarning <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1 `CHK(stopWake, 1'b1)
    stopMode <= 1'b0;
    supplyBelowWarning <= 1'b0;
    // brown-out and recovery
    supplyBelowReset <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 `CHK({cpuResetHold, oscEnable}, 2'b10)
    supplyBelowReset <= 1'b0;
    waitSig(2, n);
    `CHK(n inside {[POR:POR + 6]}, 1'b1)
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd(ADDR_WDCTL, v);
    `CHK(v, 8'h00)
    results();
  end
endmodule : wdpfs_supervisor_tb
